//--- irq_prio_pkg.sv
// constants shared by the priority controller, its cpu-side end and the link
// assumes one 100 MHz clock domain for both ends
package irq_prio_pkg;
   // =========================================
   // device register indices and fields
   localparam int         NSRC        = 8;
   localparam logic [1:0] REG_PRIO15  = 2'h0;
   localparam logic [1:0] REG_PRIO16  = 2'h1;
   localparam logic [1:0] REG_PRIO17  = 2'h2;
   localparam logic [1:0] REG_VSTAT   = 2'h3;
   localparam logic [2:0] PRIO_RESET  = 3'h4;
   localparam logic [2:0] PRIO_OFF    = 3'h0;
   localparam logic [3:0] LVL_USR_MAX = 4'h7;
   localparam logic [3:0] LVL_BLK_MAX = 4'h6;
   localparam logic [3:0] TRAP_LEVEL  = 4'h8;
   localparam logic [6:0] TRAP_VEC    = 7'h00;
   localparam int         VSTAT_LVL   = 8;
   localparam int         VSTAT_VEC   = 0;
   localparam int         VEC_OFFSET  = 8;
   // per source, index 7 first: dma6, dma7, can_a, can_b, uart_a, uart_b, audio, dma5
   localparam logic [7:0][1:0] SRC_REG =
      {REG_PRIO17, REG_PRIO17, REG_PRIO17, REG_PRIO17,
       REG_PRIO16, REG_PRIO16, REG_PRIO15, REG_PRIO15};
   localparam logic [7:0][3:0] SRC_LSB =
      {4'h0, 4'h4, 4'h8, 4'hc, 4'h4, 4'h8, 4'h0, 4'h4};
   localparam logic [7:0][6:0] SRC_VEC =
      {7'h17, 7'h16, 7'h15, 7'h14, 7'h13, 7'h12, 7'h11, 7'h10};
   // =========================================
   // cpu-side end registers
   localparam logic [2:0] H_CTRL  = 3'h0;
   localparam logic [2:0] H_STAT  = 3'h1;
   localparam logic [2:0] H_IST   = 3'h2;
   localparam logic [2:0] H_ICLR  = 3'h3;
   localparam logic [2:0] H_IEN   = 3'h4;
   localparam logic [2:0] H_DADDR = 3'h5;
   localparam logic [2:0] H_DDATA = 3'h6;
   localparam int CTRL_NEST  = 0;
   localparam int CTRL_MASK  = 1;
   localparam int CTRL_UNMSK = 2;
   localparam int CTRL_BLK   = 3;
   localparam int CTRL_TCLR  = 4;
   localparam int NEV        = 3;
   localparam int EV_TAKE    = 0;
   localparam int EV_TRAP    = 1;
   localparam int EV_UNDER   = 2;
   localparam int STK_DEPTH  = 8;
   localparam logic [3:0] SP_FULL = 4'h8;
   localparam int STAT_LVL = 0;
   localparam int STAT_SP  = 4;
   localparam int STAT_VEC = 8;
   // =========================================
   // timed block window
   localparam int          CLK_MHZ     = 100;
   localparam int          BLK_TIME_NS = 1000;
   localparam logic [15:0] BLK_CYC     = 16'((BLK_TIME_NS * CLK_MHZ) / 1000);
endpackage : irq_prio_pkg

//--- irq_link_if.sv
// link between the priority controller and the cpu-side end
// assumes both ends share clk; the testbench instantiates and joins them
`timescale 1ns/1ps
interface irq_link_if;
   logic [1:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic [3:0]  cpu_level;
   logic        in_service;
   logic        nest_dis;
   logic        blk_active;
   logic        trap_clr;
   logic        irq_valid;
   logic        irq_trap;
   logic [6:0]  irq_vec;
   logic [3:0]  irq_lvl;
   modport ctrl (
      input  reg_addr, reg_wdata, reg_wr, reg_rd, cpu_level, in_service,
      input  nest_dis, blk_active, trap_clr,
      output reg_rdata, irq_valid, irq_trap, irq_vec, irq_lvl
   );
   modport cpu (
      output reg_addr, reg_wdata, reg_wr, reg_rd, cpu_level, in_service,
      output nest_dis, blk_active, trap_clr,
      input  reg_rdata, irq_valid, irq_trap, irq_vec, irq_lvl
   );
endinterface : irq_link_if

//--- irq_prio_ctrl.sv
// priority controller: eight source priority fields, vector status, arbitration
// assumes source requests and trap events come from logic on clk
// Operation
// - 3-bit priority, 7 top, zero disables
// - all priority fields reset to four
// - unused bits read zero, ignore writes
// - register 15: dma5 6-4, audio 2-0
// - register 16: uart b 10-8, uart a 6-4
// - register 17: can b, can a, dma7, dma6
// - status 11-8 shows new cpu level
// - status 6-0 shows vector minus eight; here it shows st.vec with no offset taken off
// - nesting disable blocks nested interrupts
// - software: priority, clear flag, then enable
// - software may give all one level
// - flag still set re-enters the routine
// - return restores pc, status, old level
// - trap re-entered while its flag stays
// - software masks by forcing level seven
// - cpu level masks user, never traps; here cpu level 8 also stops traps
// - timed block stops levels 1-6 only
`timescale 1ns/1ps
module irq_prio_ctrl (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [7:0]  src_req,
   input  wire logic        trap_evt,
   output logic             trap_flag,
   irq_link_if.ctrl         lnk
);
   // =========================================
   // state
   typedef struct packed {
      logic [7:0][2:0] prio;
      logic            trap;
      logic            valid;
      logic            is_trap;
      logic [6:0]      vec;
      logic [3:0]      lvl;
      logic [15:0]     rdata;
   } dev_s;

   dev_s st;
   dev_s next_st;
   logic [7:0] wr_hit;
   logic [7:0] elig;
   logic [7:0][15:0] rd_part;

   // =========================================
   // per source decode and eligibility
   genvar g;
   generate
      for (g = 0; g < irq_prio_pkg::NSRC; g++)
      begin : g_src
         assign wr_hit[g] = lnk.reg_wr && (lnk.reg_addr == irq_prio_pkg::SRC_REG[g]);
         assign rd_part[g] = (lnk.reg_addr == irq_prio_pkg::SRC_REG[g])
                           ? (16'(st.prio[g]) << irq_prio_pkg::SRC_LSB[g]) : 16'h0000;
         // zero field never requests; level must beat the cpu
         assign elig[g] = src_req[g]
                        && (st.prio[g] != irq_prio_pkg::PRIO_OFF)
                        && ({1'b0, st.prio[g]} > lnk.cpu_level)
                        && !(lnk.blk_active && ({1'b0, st.prio[g]} <= irq_prio_pkg::LVL_BLK_MAX))
                        && !(lnk.nest_dis && lnk.in_service);
      end
   endgenerate

   // =========================================
   // next state
   // arbitration is recomputed every cycle, so a source whose flag
   // is still set after the return simply wins again
   always_comb
   begin
      logic [15:0] rd;
      logic [3:0]  best;
      next_st = st;
      rd = 16'h0000;
      best = 4'h0;
      for (int i = 0; i < irq_prio_pkg::NSRC; i++)
      begin
         if (wr_hit[i])
         begin
            next_st.prio[i] = lnk.reg_wdata[irq_prio_pkg::SRC_LSB[i] +: 3];
         end
         rd = rd | rd_part[i];
      end
      next_st.valid = 1'b0;
      next_st.is_trap = 1'b0;
      next_st.vec = 7'h00;
      next_st.lvl = 4'h0;
      // strict compare: on a tie the lower source index keeps the win
      for (int i = 0; i < irq_prio_pkg::NSRC; i++)
      begin
         if (elig[i] && ({1'b0, st.prio[i]} > best))
         begin
            best = {1'b0, st.prio[i]};
            next_st.valid = 1'b1;
            next_st.vec = irq_prio_pkg::SRC_VEC[i];
            next_st.lvl = {1'b0, st.prio[i]};
         end
      end
      // traps ignore masking and timed block; only their own level stops them
      if (st.trap && (irq_prio_pkg::TRAP_LEVEL > lnk.cpu_level))
      begin
         next_st.valid = 1'b1;
         next_st.is_trap = 1'b1;
         next_st.vec = irq_prio_pkg::TRAP_VEC;
         next_st.lvl = irq_prio_pkg::TRAP_LEVEL;
      end
      // a new trap beats a clear in the same cycle
      next_st.trap = trap_evt | (st.trap & ~lnk.trap_clr);
      if (lnk.reg_addr == irq_prio_pkg::REG_VSTAT)
      begin
         rd = 16'h0000;
         rd[irq_prio_pkg::VSTAT_LVL +: 4] = st.lvl;
         rd[irq_prio_pkg::VSTAT_VEC +: 7] = st.vec;
      end
      next_st.rdata = lnk.reg_rd ? rd : 16'h0000;
   end

   // =========================================
   // register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '0;
         st.prio <= {irq_prio_pkg::NSRC{irq_prio_pkg::PRIO_RESET}};
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign lnk.reg_rdata = st.rdata;
   assign lnk.irq_valid = st.valid;
   assign lnk.irq_trap = st.is_trap;
   assign lnk.irq_vec = st.vec;
   assign lnk.irq_lvl = st.lvl;
   assign trap_flag = st.trap;
endmodule : irq_prio_ctrl

//--- irq_cpu_end.sv
// cpu-side end: holds the cpu level and its save stack, takes interrupts,
// runs the timed block, and gives software a register port
// assumes the controller end is on the same clk
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module irq_cpu_end (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [2:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic        ret,
   output logic [15:0]      rdata,
   output logic             irq_out,
   irq_link_if.cpu          lnk
);
   // =========================================
   // state
   typedef enum logic [1:0] { RUN = 2'b01, SETTLE = 2'b10 } ph_e;
   typedef struct packed {
      ph_e             ph;
      logic [3:0]      lvl;
      logic [7:0][3:0] stk;
      logic [3:0]      sp;
      logic            nest;
      logic [15:0]     cnt;
      logic            blk;
      logic            tclr;
      logic [2:0]      ist;
      logic [2:0]      ien;
      logic            irq;
      logic [1:0]      daddr;
      logic [15:0]     ddata;
      logic            dpend;
      logic [6:0]      vec;
      logic            dwr;
      logic            drd;
      logic [15:0]     dwd;
      logic [15:0]     rdata;
   } cpu_s;

   cpu_s st;
   cpu_s next_st;

   // =========================================
   // next state
   // the level change needs one cycle to reach the controller's
   // registered request, so SETTLE ignores the stale one
   always_comb
   begin
      logic [irq_prio_pkg::NEV-1:0] ev;
      logic                         push;
      logic                         pop;
      logic [3:0]                   nlvl;
      next_st = st;
      ev = '0;
      push = 1'b0;
      pop = 1'b0;
      nlvl = st.lvl;
      next_st.ph = RUN;
      next_st.tclr = 1'b0;
      next_st.dwr = 1'b0;
      next_st.drd = 1'b0;
      next_st.dpend = st.drd;
      if (st.dpend)
      begin
         next_st.ddata = lnk.reg_rdata;
      end
      if (wr && (addr == irq_prio_pkg::H_CTRL))
      begin
         next_st.nest = wdata[irq_prio_pkg::CTRL_NEST];
         next_st.tclr = wdata[irq_prio_pkg::CTRL_TCLR];
         if (wdata[irq_prio_pkg::CTRL_BLK])
         begin
            next_st.cnt = irq_prio_pkg::BLK_CYC;
         end
         if (wdata[irq_prio_pkg::CTRL_MASK])
         begin
            push = 1'b1;
            nlvl = (st.lvl > irq_prio_pkg::LVL_USR_MAX) ? st.lvl : irq_prio_pkg::LVL_USR_MAX;
         end
         else if (wdata[irq_prio_pkg::CTRL_UNMSK])
         begin
            pop = 1'b1;
         end
      end
      else if (ret)
      begin
         pop = 1'b1;
      end
      else if ((st.ph == RUN) && lnk.irq_valid && (lnk.irq_lvl > st.lvl)
               && (st.sp != irq_prio_pkg::SP_FULL))
      begin
         push = 1'b1;
         nlvl = lnk.irq_lvl;
         next_st.vec = lnk.irq_vec;
         ev[irq_prio_pkg::EV_TAKE] = 1'b1;
         ev[irq_prio_pkg::EV_TRAP] = lnk.irq_trap;
      end
      if (push && (st.sp != irq_prio_pkg::SP_FULL))
      begin
         next_st.stk[st.sp[2:0]] = st.lvl;
         next_st.sp = st.sp + 4'h1;
         next_st.lvl = nlvl;
         next_st.ph = SETTLE;
      end
      else if (pop && (st.sp != 4'h0))
      begin
         next_st.lvl = st.stk[3'(st.sp - 4'h1)];
         next_st.sp = st.sp - 4'h1;
         next_st.ph = SETTLE;
      end
      else if (pop)
      begin
         ev[irq_prio_pkg::EV_UNDER] = 1'b1;
      end
      if (st.cnt != 16'h0000 && !(wr && addr == irq_prio_pkg::H_CTRL && wdata[irq_prio_pkg::CTRL_BLK]))
      begin
         next_st.cnt = st.cnt - 16'h0001;
      end
      next_st.blk = (next_st.cnt != 16'h0000);
      if (wr && (addr == irq_prio_pkg::H_IEN))
      begin
         next_st.ien = wdata[irq_prio_pkg::NEV-1:0];
      end
      if (wr && (addr == irq_prio_pkg::H_DADDR))
      begin
         next_st.daddr = wdata[1:0];
         next_st.drd = 1'b1;
      end
      if (wr && (addr == irq_prio_pkg::H_DDATA))
      begin
         next_st.dwr = 1'b1;
         next_st.dwd = wdata;
      end
      // an event in the clearing cycle survives the clear
      next_st.ist = ev | (st.ist & ~((wr && addr == irq_prio_pkg::H_ICLR) ? wdata[irq_prio_pkg::NEV-1:0] : 3'h0));
      next_st.irq = |(next_st.ist & next_st.ien);
      next_st.rdata = 16'h0000;
      if (rd)
      begin
         unique case (addr)
            irq_prio_pkg::H_CTRL:  next_st.rdata = 16'(st.nest);
            irq_prio_pkg::H_STAT:  next_st.rdata = {1'b0, st.vec, st.sp, st.lvl};
            irq_prio_pkg::H_IST:   next_st.rdata = 16'(st.ist);
            irq_prio_pkg::H_IEN:   next_st.rdata = 16'(st.ien);
            irq_prio_pkg::H_DADDR: next_st.rdata = 16'(st.daddr);
            irq_prio_pkg::H_DDATA: next_st.rdata = st.ddata;
            default:               next_st.rdata = 16'h0000;
         endcase
      end
   end

   // =========================================
   // register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '0;
         st.ph <= RUN;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign irq_out = st.irq;
   assign lnk.reg_addr = st.daddr;
   assign lnk.reg_wdata = st.dwd;
   assign lnk.reg_wr = st.dwr;
   assign lnk.reg_rd = st.drd;
   assign lnk.cpu_level = st.lvl;
   assign lnk.in_service = (st.sp != 4'h0);
   assign lnk.nest_dis = st.nest;
   assign lnk.blk_active = st.blk;
   assign lnk.trap_clr = st.tclr;
endmodule : irq_cpu_end

//--- irq_link_sva.sv
// assertions on the link between the priority controller and the cpu-side end
// assumes one clock and an async active-low reset; sees only the link signals
`timescale 1ns/1ps
module irq_link_sva (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [1:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [3:0]  cpu_level,
   input wire logic        in_service,
   input wire logic        nest_dis,
   input wire logic        blk_active,
   input wire logic        irq_valid,
   input wire logic        irq_trap,
   input wire logic [6:0]  irq_vec,
   input wire logic [3:0]  irq_lvl
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // =========================================
   // register reads: unused bits must come back zero
   logic usr;
   assign usr = irq_valid && !irq_trap; // a user source is offered
   prio15_unused_a: assert property ($past(reg_rd) && $past(reg_addr) == 2'h0 |-> reg_rdata[15:7] == 9'h000 && !reg_rdata[3])
      else $error("unused bits of priority word 15 not zero");
   prio16_unused_a: assert property ($past(reg_rd) && $past(reg_addr) == 2'h1 |-> reg_rdata[15:11] == 5'h00 && !reg_rdata[7] && reg_rdata[3:0] == 4'h0)
      else $error("unused bits of priority word 16 not zero");
   prio17_unused_a: assert property ($past(reg_rd) && $past(reg_addr) == 2'h2 |-> !reg_rdata[15] && !reg_rdata[11] && !reg_rdata[7] && !reg_rdata[3])
      else $error("unused bits of priority word 17 not zero");
   vstat_unused_a: assert property ($past(reg_rd) && $past(reg_addr) == 2'h3 |-> reg_rdata[15:12] == 4'h0 && !reg_rdata[7])
      else $error("unused bits of vector status not zero");
   // the status word must carry the winner registered in the read cycle
   vstat_fields_a: assert property ($past(reg_rd) && $past(reg_addr) == 2'h3
      |-> reg_rdata[11:8] == $past(irq_lvl) && reg_rdata[6:0] == $past(irq_vec))
      else $error("vector status fields differ from the offered winner");
   // =========================================
   // arbitration: offers only what the cpu level and windows allow
   user_level_a: assert property (usr |-> irq_lvl != 4'h0 && irq_lvl <= 4'h7 && irq_lvl > $past(cpu_level))
      else $error("user source offered at or below cpu level");
   block_window_a: assert property (usr && $past(blk_active) |-> irq_lvl == 4'h7)
      else $error("level below 7 offered in timed block");
   nest_block_a: assert property (usr |-> !($past(nest_dis) && $past(in_service)))
      else $error("nested user source offered with nesting off");
   trap_offer_a: assert property (irq_trap |-> irq_valid && irq_lvl == irq_prio_pkg::TRAP_LEVEL && irq_vec == irq_prio_pkg::TRAP_VEC)
      else $error("trap offer with wrong level or vector");
   cover property (usr);
   cover property (irq_trap);
   cover property (usr && $past(blk_active));
endmodule : irq_link_sva

//--- interrupt_priority_and_vector_status_bench.sv
// self-checking bench: both ends joined over the link, driven from the software port
// assumes 100 MHz clk; ce is driven here so one scenario checks that low ce freezes the cpu-side end
`timescale 1ns/1ps
module interrupt_priority_and_vector_status_bench;
   logic        clk;
   logic        rst_n;
   logic        ce;
   logic [2:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic        ret;
   logic [7:0]  src_req;
   logic        trap_evt;
   logic [15:0] rdata;
   logic        irq_out;
   logic        trap_flag;
   logic [15:0] v;
   int          n_fail;
   int          n_compared;
   irq_link_if lnk ();
   irq_prio_ctrl u_irq_prio_ctrl (.clk(clk), .rst_n(rst_n), .ce(ce), .src_req(src_req), .trap_evt(trap_evt),
      .trap_flag(trap_flag), .lnk(lnk));
   irq_cpu_end u_irq_cpu_end (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .ret(ret), .rdata(rdata), .irq_out(irq_out), .lnk(lnk));
   irq_link_sva u_irq_link_sva (.clk(clk), .rst_n(rst_n), .reg_addr(lnk.reg_addr), .reg_rd(lnk.reg_rd),
      .reg_rdata(lnk.reg_rdata), .cpu_level(lnk.cpu_level), .in_service(lnk.in_service), .nest_dis(lnk.nest_dis),
      .blk_active(lnk.blk_active), .irq_valid(lnk.irq_valid), .irq_trap(lnk.irq_trap), .irq_vec(lnk.irq_vec),
      .irq_lvl(lnk.irq_lvl));
   // =========================================
   // shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stands only in the cycle after the strobe, so sample it there
   task automatic rd_reg(input logic [2:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task automatic dev_wr(input logic [1:0] i, input logic [15:0] d);
      wr_reg(irq_prio_pkg::H_DADDR, {14'h0000, i});
      wr_reg(irq_prio_pkg::H_DDATA, d);
   endtask : dev_wr
   task automatic dev_rd(input logic [1:0] i);
      wr_reg(irq_prio_pkg::H_DADDR, {14'h0000, i});
      repeat (4) @(posedge clk);
      rd_reg(irq_prio_pkg::H_DDATA);
   endtask : dev_rd
   task automatic req(input logic [7:0] r);
      @(posedge clk);
      src_req <= r;
   endtask : req
   task automatic do_ret();
      @(posedge clk);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
   endtask : do_ret
   // take settles in a few cycles; compare stack depth and cpu level only
   task automatic stat(input logic [3:0] sp, input logic [3:0] lvl);
      repeat (6) @(posedge clk);
      rd_reg(irq_prio_pkg::H_STAT);
      check({8'h00, v[7:0]}, {8'h00, sp, lvl});
   endtask : stat
   // =========================================
   // scenarios
   task automatic regs_test();
      logic [15:0] rst_v [4];
      logic [15:0] one_v [4];
      rst_v = '{16'h0044, 16'h0440, 16'h4444, 16'h0000};
      one_v = '{16'h0077, 16'h0770, 16'h7777, 16'h0000};
      for (int i = 0; i < 4; i++)
      begin
         dev_rd(i[1:0]);
         check(v, rst_v[i]);
         dev_wr(i[1:0], 16'hffff);
         dev_rd(i[1:0]);
         check(v, one_v[i]);
      end
      rd_reg(3'h7);
      check(v, 16'h0000);
   endtask : regs_test
   task automatic take_test();
      wr_reg(irq_prio_pkg::H_IEN, 16'h0007);
      dev_wr(2'h0, 16'h0000);
      req(8'h03);
      stat(4'h0, 4'h0);
      dev_wr(2'h0, 16'h0030);
      stat(4'h1, 4'h3);
      check({9'h000, v[14:8]}, 16'h0010);
      check({15'h0000, irq_out}, 16'h0001);
      do_ret();
      stat(4'h1, 4'h3);
      req(8'h00);
      do_ret();
      stat(4'h0, 4'h0);
      do_ret();
      rd_reg(irq_prio_pkg::H_IST);
      check(v, 16'h0005);
      wr_reg(irq_prio_pkg::H_ICLR, 16'h0007);
      rd_reg(irq_prio_pkg::H_IST);
      check({v[15:1], irq_out}, 16'h0000);
   endtask : take_test
   // mask raises the level to 7, so only the trap gets through
   task automatic mask_trap_test();
      wr_reg(irq_prio_pkg::H_IEN, 16'h0000);
      wr_reg(irq_prio_pkg::H_CTRL, 16'h0002);
      dev_wr(2'h0, 16'h0070);
      req(8'h01);
      stat(4'h1, 4'h7);
      @(posedge clk);
      trap_evt <= 1'b1;
      @(posedge clk);
      trap_evt <= 1'b0;
      stat(4'h2, 4'h8);
      do_ret();
      stat(4'h2, 4'h8);
      wr_reg(irq_prio_pkg::H_CTRL, 16'h0010);
      do_ret();
      stat(4'h1, 4'h7);
      check({15'h0000, trap_flag}, 16'h0000);
      wr_reg(irq_prio_pkg::H_CTRL, 16'h0004);
      stat(4'h1, 4'h7);
      rd_reg(irq_prio_pkg::H_IST);
      check({v[15:1], irq_out}, 16'h0002);
      req(8'h00);
      do_ret();
      wr_reg(irq_prio_pkg::H_ICLR, 16'h0007);
   endtask : mask_trap_test
   task automatic block_test();
      dev_wr(2'h0, 16'h0060);
      wr_reg(irq_prio_pkg::H_CTRL, 16'h0008);
      req(8'h01);
      stat(4'h0, 4'h0);
      dev_wr(2'h0, 16'h0070);
      stat(4'h1, 4'h7);
      req(8'h00);
      do_ret();
      dev_wr(2'h0, 16'h0060);
      repeat (100) @(posedge clk);
      req(8'h01);
      stat(4'h1, 4'h6);
      req(8'h00);
      do_ret();
   endtask : block_test
   task automatic nest_test();
      wr_reg(irq_prio_pkg::H_CTRL, 16'h0001);
      dev_wr(2'h0, 16'h0037);
      req(8'h01);
      stat(4'h1, 4'h3);
      req(8'h03);
      stat(4'h1, 4'h3);
      req(8'h00);
      do_ret();
      wr_reg(irq_prio_pkg::H_CTRL, 16'h0000);
   endtask : nest_test
   // equal levels: the lowest source index must win the tie
   task automatic tie_test();
      dev_wr(2'h1, 16'h0550);
      wr_reg(irq_prio_pkg::H_ICLR, 16'h0007);
      req(8'h0c);
      stat(4'h1, 4'h5);
      check({9'h000, v[14:8]}, {9'h000, irq_prio_pkg::SRC_VEC[2]});
      req(8'h00);
      do_ret();
   endtask : tie_test
   // a mask write while ce is low must leave stack and level untouched
   task automatic freeze_test();
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(irq_prio_pkg::H_CTRL, 16'h0002);
      @(posedge clk);
      ce <= 1'b1;
      stat(4'h0, 4'h0);
   endtask : freeze_test
   task automatic wrap_up();
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   // =========================================
   // clock, watchdog and main sequence
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // the sequence needs about 420 cycles; this leaves ample margin
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      wrap_up();
   end
   initial
   begin
      {rst_n, addr, wdata, wr, rd, ret, src_req, trap_evt} = '0;
      ce         = 1'b1;
      n_fail     = 0;
      n_compared = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      regs_test();
      take_test();
      mask_trap_test();
      block_test();
      nest_test();
      tie_test();
      freeze_test();
      wrap_up();
   end
endmodule : interrupt_priority_and_vector_status_bench
